// >>> logic/ssx_pkg.sv
/*
 * constants, field layouts and state type of the enhanced serial read block
 * assumes: one core clock; registers reached over an ahb-lite slave port
 */
`default_nettype none
package ssx_pkg;
    localparam int LANE_N = 8;
    // register byte offsets
    localparam logic [7:0] OFS_MAIN = 8'h00;
    localparam logic [7:0] OFS_FRAMES = 8'h04;
    localparam logic [7:0] OFS_DIV = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_DATA = 8'h60;
    localparam logic [7:0] OFS_ENH = 8'hf4;
    localparam logic [7:0] OFS_EDGE = 8'hf8;
    localparam logic [7:0] OFS_INSTR = 8'hfc;
    // main_control fields
    localparam int MC_FSIZE_LSB = 0;
    localparam int MC_PHASE = 6;
    localparam int MC_POLARITY = 7;
    localparam int MC_LANE_LSB = 21;
    // enhanced_control fields
    localparam int EC_PFMT_LSB = 0;
    localparam int EC_ALEN_LSB = 2;
    localparam int EC_ILEN_LSB = 8;
    localparam int EC_WAIT_LSB = 11;
    localparam int EC_DDR = 16;
    localparam int EC_IDDR = 17;
    // reset values
    localparam logic [31:0] MAIN_RST = 32'h0000_0007;
    localparam logic [31:0] ENH_RST = 32'h0000_0000;
    localparam logic [15:0] FRAMES_RST = 16'h0000;
    localparam logic [15:0] DIV_RST = 16'h0002;
    localparam logic [15:0] EDGE_RST = 16'h0000;
    localparam logic [15:0] INSTR_RST = 16'h0000;
    // lane and phase format codes, word transfer size
    localparam logic [1:0] LF_STD = 2'h0;
    localparam logic [1:0] PF_STD = 2'h0;
    localparam logic [1:0] PF_ALL_MULTI = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INSTR,
        ST_ADDR,
        ST_WAIT,
        ST_DATA,
        ST_DONE
    } ssx_state_t;

    // lanes per beat: top lane index is this minus one
    function automatic logic [3:0] lanes_of(input logic [1:0] f);
        unique case (f)
            2'h1: lanes_of = 4'd2;
            2'h2: lanes_of = 4'd4;
            2'h3: lanes_of = 4'd8;
            default: lanes_of = 4'd1;
        endcase
    endfunction

    function automatic logic [6:0] inst_bits(input logic [1:0] code);
        unique case (code)
            2'h1: inst_bits = 7'd4;
            2'h2: inst_bits = 7'd8;
            2'h3: inst_bits = 7'd16;
            default: inst_bits = 7'd0;
        endcase
    endfunction
endpackage
`default_nettype wire

// >>> logic/ssx_sclk_gen.sv
/*
 * serial clock timing: half-period toggle pulses and the launch pulse
 * assumes: run is held high for the whole time the serial clock moves
 */
`default_nettype none
module ssx_sclk_gen #(
    parameter int DW = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [DW-1:0] divider,
    input wire logic [DW-1:0] offset,
    output logic toggle,
    output logic launch
);
    import ssx_pkg::*;

    if (DW < 2 || DW > 16) begin : g_chk
        $error("ssx_sclk_gen: DW must lie in 2..16");
    end

    logic [DW-1:0] cnt;
    logic [DW-1:0] next_cnt;
    logic [DW-1:0] half;
    logic [DW-1:0] last;
    logic [DW-1:0] off_eff;

    always_comb begin
        half = (divider < DW'(2)) ? DW'(1) : (divider >> 1);
        last = half - DW'(1);
        if (divider <= DW'(2)) begin
            off_eff = '0;
        end else if (offset > last) begin
            off_eff = last;
        end else begin
            off_eff = offset;
        end
        toggle = run && (cnt == last);
        launch = run && (cnt == last - off_eff);
        next_cnt = (!run || toggle) ? '0 : cnt + DW'(1);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule // ssx_sclk_gen
`default_nettype wire

// >>> logic/ssx_enhanced_read.sv
/*
 * multi-lane / double-rate / execute-in-place serial read master with ahb-lite registers
 * assumes: xip_en comes from the cache controller on hclk; rxd is asynchronous
 */
//
// Function
// - phase format 10b sends instruction and address over all lanes
// - lane format 11b, 10b, 01b select eight, four, two lanes
// - address length code counts four address bits per step, up to 60
// - data port write starts a read: instruction, address, turnaround, then frame count plus one frames
// - single-line mode samples input on lane 1
// - one fixed lane-to-pin mapping for every protocol
// - double rate only in clock modes 0 and 3
// - bit 16 doubles address and data, bit 17 doubles instruction
// - double-rate bits ignored in single-line format
// - launch offset picks the core cycle that drives each double-rate bit
// - offset 0 drives edge aligned, offset 1 one cycle early
// - divider two always drives edge aligned
// - cache enable routes bus reads to serial reads and drops bus writes
// - each bus read becomes a serial read answered in the same transfer
// - serial address is the low bus address bits up to its length
// - execute-in-place needs a multi-lane format; not enforced, cache reads also run in single-line format
// - execute-in-place read runs the instruction, address, turnaround and data phases
// - turnaround equals the programmed count of serial periods
// - send instruction and control once, receive frames, then deselect
//
`default_nettype none
module ssx_enhanced_read #(
    parameter int DIV_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic xip_en,
    output logic sclk_out,
    output logic ss_n,
    output logic [ssx_pkg::LANE_N-1:0] txd,
    output logic [ssx_pkg::LANE_N-1:0] txd_oe,
    input wire logic [ssx_pkg::LANE_N-1:0] rxd
);
    import ssx_pkg::*;

    if (DIV_W < 2 || DIV_W > 16) begin : g_chk
        $error("ssx_enhanced_read: DIV_W must lie in 2..16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // register and bus state
    logic [31:0] main_control;
    logic [31:0] enhanced_control;
    logic [15:0] read_frame_count;
    logic [15:0] clock_divider;
    logic [15:0] drive_edge;
    logic [15:0] instr_value;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic xip_pend;
    logic [31:0] xip_addr;
    logic rx_valid;
    logic [31:0] next_main;
    logic [31:0] next_enh;
    logic [15:0] next_frame_cnt;
    logic [15:0] next_div;
    logic [15:0] next_edge;
    logic [15:0] next_instr;
    logic next_dp_valid;
    logic next_dp_write;
    logic [7:0] next_dp_addr;
    logic next_xip_pend;
    logic [31:0] next_xip_addr;
    logic next_rx_valid;
    logic next_hreadyout;
    logic [31:0] next_hrdata;
    logic ap;
    logic reg_go;
    logic rd_clr;

    // engine state
    ssx_state_t state;
    ssx_state_t next_state;
    logic [63:0] sr;
    logic [63:0] next_sr;
    logic [6:0] rem;
    logic [6:0] next_rem;
    logic [5:0] wcnt;
    logic [5:0] next_wcnt;
    logic [5:0] fb;
    logic [5:0] next_fb;
    logic [16:0] frames;
    logic [16:0] next_frames;
    logic [31:0] rsr;
    logic [31:0] next_rsr;
    logic [31:0] rx_word;
    logic [31:0] next_rx_word;
    logic [31:0] addr_lat;
    logic [31:0] next_addr;
    logic par;
    logic next_par;
    logic hold;
    logic next_hold;
    logic own_xip;
    logic next_own;
    logic next_sclk;
    logic next_ss_n;
    logic [LANE_N-1:0] next_txd;
    logic [LANE_N-1:0] next_oe;
    logic [LANE_N-1:0] rxd_m;
    logic [LANE_N-1:0] rxd_s;
    logic [3:0] next_w;
    logic enter;
    logic frame_ev;

    // decoded configuration
    logic [1:0] fmt;
    logic multi;
    logic cpha;
    logic cpol;
    logic mode_ok;
    logic [3:0] nl;
    logic [3:0] w_i;
    logic [3:0] w_a;
    logic [3:0] w_d;
    logic ddr_i;
    logic ddr_ad;
    logic [6:0] ibits;
    logic [6:0] abits;
    logic [5:0] fsize;
    logic [31:0] fmask;
    logic [3:0] cur_w;
    logic cur_ddr;
    logic start;
    logic fin;
    logic run;
    logic toggle;
    logic launch;
    logic step;
    logic sample;
    logic [31:0] rx_in;

    function automatic logic [3:0] ph_w(input ssx_state_t s);
        if (s == ST_INSTR) begin
            ph_w = w_i;
        end else if (s == ST_ADDR) begin
            ph_w = w_a;
        end else begin
            ph_w = w_d;
        end
    endfunction

    function automatic logic ph_ddr(input ssx_state_t s);
        ph_ddr = (s == ST_INSTR) ? ddr_i : ddr_ad;
    endfunction

    function automatic ssx_state_t follow(input ssx_state_t s);
        if (s == ST_IDLE && ibits != 7'd0) begin
            follow = ST_INSTR;
        end else if ((s == ST_IDLE || s == ST_INSTR) && abits != 7'd0) begin
            follow = ST_ADDR;
        end else if (s != ST_WAIT && enhanced_control[EC_WAIT_LSB +: 5] != 5'd0) begin
            follow = ST_WAIT;
        end else begin
            follow = ST_DATA;
        end
    endfunction

    function automatic logic [31:0] read_reg(input logic [7:0] a);
        unique case (a)
            OFS_MAIN: read_reg = main_control;
            OFS_FRAMES: read_reg = {16'h0000, read_frame_count};
            OFS_DIV: read_reg = {16'h0000, clock_divider};
            OFS_STATUS: read_reg = {29'h0000_0000, own_xip, rx_valid, state != ST_IDLE};
            OFS_DATA: read_reg = rx_word;
            OFS_ENH: read_reg = enhanced_control;
            OFS_EDGE: read_reg = {16'h0000, drive_edge};
            OFS_INSTR: read_reg = {16'h0000, instr_value};
            default: read_reg = 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode
    always_comb begin
        fmt = main_control[MC_LANE_LSB +: 2];
        multi = (fmt != LF_STD);
        cpha = main_control[MC_PHASE];
        cpol = main_control[MC_POLARITY];
        mode_ok = (cpha == cpol);
        nl = lanes_of(fmt);
        w_i = (multi && enhanced_control[EC_PFMT_LSB +: 2] == PF_ALL_MULTI) ? nl : 4'd1;
        w_a = (multi && enhanced_control[EC_PFMT_LSB +: 2] != PF_STD) ? nl : 4'd1;
        w_d = multi ? nl : 4'd1;
        ddr_i = multi && mode_ok && enhanced_control[EC_IDDR];
        ddr_ad = multi && mode_ok && enhanced_control[EC_DDR];
        ibits = inst_bits(enhanced_control[EC_ILEN_LSB +: 2]);
        abits = 7'({enhanced_control[EC_ALEN_LSB +: 4], 2'b00});
        fsize = 6'(main_control[MC_FSIZE_LSB +: 5]) + 6'd1;
        fmask = (fsize == 6'd32) ? 32'hffff_ffff : ((32'h0000_0001 << fsize) - 32'h0000_0001);
        cur_w = ph_w(state);
        cur_ddr = ph_ddr(state);
        step = cur_ddr ? launch : (toggle && (par != cpha));
        sample = toggle && (cur_ddr || (par == cpha));
        rx_in = multi ? (32'(rxd_s) & ((32'h0000_0001 << cur_w) - 32'h0000_0001))
                      : {31'h0000_0000, rxd_s[1]};
        fin = (state == ST_DONE) && (sclk_out == cpol);
        run = (state != ST_IDLE) && !fin;
        start = (state == ST_IDLE) && (xip_pend || reg_go);
    end

    ssx_sclk_gen #(
        .DW(DIV_W)
    ) u_sclk (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .divider(DIV_W'(clock_divider)),
        .offset(DIV_W'(drive_edge)),
        .toggle(toggle),
        .launch(launch)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave and registers
    always_comb begin
        next_main = main_control;
        next_enh = enhanced_control;
        next_frame_cnt = read_frame_count;
        next_div = clock_divider;
        next_edge = drive_edge;
        next_instr = instr_value;
        next_xip_pend = xip_pend;
        next_xip_addr = xip_addr;
        next_hreadyout = hreadyout;
        next_hrdata = hrdata;
        reg_go = 1'b0;
        ap = hsel && htrans[1] && hready;
        rd_clr = ap && !hwrite && !xip_en && (haddr[7:0] == OFS_DATA);
        next_dp_valid = ap && !xip_en;
        next_dp_write = hwrite && (hsize == HSIZE_WORD);
        next_dp_addr = haddr[7:0];
        if (dp_valid && dp_write) begin
            unique case (dp_addr)
                OFS_MAIN: next_main = hwdata;
                OFS_FRAMES: next_frame_cnt = hwdata[15:0];
                OFS_DIV: next_div = hwdata[15:0];
                OFS_ENH: next_enh = hwdata;
                OFS_EDGE: next_edge = hwdata[15:0];
                OFS_INSTR: next_instr = hwdata[15:0];
                OFS_DATA: reg_go = !xip_en;
                default: ;
            endcase
        end
        if (start && xip_pend) begin
            next_xip_pend = 1'b0;
        end
        if (ap && !hwrite && !xip_en) begin
            next_hrdata = read_reg(haddr[7:0]);
        end
        if (ap && !hwrite && xip_en) begin
            next_xip_pend = 1'b1;
            next_xip_addr = haddr;
            next_hreadyout = 1'b0;
        end
        if (fin && own_xip) begin
            next_hrdata = rx_word;
            next_hreadyout = 1'b1;
        end
        next_rx_valid = (rx_valid && !rd_clr) || (frame_ev && !own_xip);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_control <= MAIN_RST;
            enhanced_control <= ENH_RST;
            read_frame_count <= FRAMES_RST;
            clock_divider <= DIV_RST;
            drive_edge <= EDGE_RST;
            instr_value <= INSTR_RST;
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            xip_pend <= 1'b0;
            xip_addr <= 32'h0000_0000;
            rx_valid <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            main_control <= next_main;
            enhanced_control <= next_enh;
            read_frame_count <= next_frame_cnt;
            clock_divider <= next_div;
            drive_edge <= next_edge;
            instr_value <= next_instr;
            dp_valid <= next_dp_valid;
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            xip_pend <= next_xip_pend;
            xip_addr <= next_xip_addr;
            rx_valid <= next_rx_valid;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial engine
    always_comb begin
        next_state = state;
        next_sr = sr;
        next_rem = rem;
        next_wcnt = wcnt;
        next_fb = fb;
        next_frames = frames;
        next_rsr = rsr;
        next_rx_word = rx_word;
        next_addr = addr_lat;
        next_par = par;
        next_hold = hold;
        next_own = own_xip;
        next_sclk = sclk_out;
        enter = 1'b0;
        frame_ev = 1'b0;
        if (toggle) begin
            next_sclk = !sclk_out;
            next_par = !par;
        end
        unique case (state)
            ST_IDLE: begin
                next_sclk = cpol;
                if (start) begin
                    next_own = xip_pend;
                    next_addr = xip_pend ? xip_addr : hwdata;
                    next_frames = xip_pend ? 17'd1 : 17'(read_frame_count) + 17'd1;
                    next_par = 1'b0;
                    next_state = follow(ST_IDLE);
                    next_hold = ph_ddr(next_state) || cpha;
                    enter = 1'b1;
                end
            end
            ST_INSTR, ST_ADDR: begin
                if (step) begin
                    if (hold) begin
                        next_hold = 1'b0;
                    end else if (rem > 7'(cur_w)) begin
                        next_sr = sr << cur_w;
                        next_rem = rem - 7'(cur_w);
                    end else begin
                        next_state = follow(state);
                        next_hold = ph_ddr(next_state) && !cur_ddr; // hold only on change from single to double rate
                        enter = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (toggle) begin
                    if (wcnt == 6'd1) begin
                        next_state = ST_DATA;
                        enter = 1'b1;
                    end else begin
                        next_wcnt = wcnt - 6'd1;
                    end
                end
            end
            ST_DATA: begin
                if (sample) begin
                    next_rsr = (rsr << cur_w) | rx_in;
                    if (7'(fb) + 7'(cur_w) >= 7'(fsize)) begin
                        next_rx_word = next_rsr & fmask;
                        frame_ev = 1'b1;
                        next_fb = 6'd0;
                        if (frames == 17'd1) begin
                            next_state = ST_DONE;
                        end else begin
                            next_frames = frames - 17'd1;
                        end
                    end else begin
                        next_fb = fb + 6'(cur_w);
                    end
                end
            end
            ST_DONE: begin
                if (fin) begin
                    next_state = ST_IDLE;
                    next_sclk = cpol;
                end
            end
        endcase
        if (enter) begin
            if (next_state == ST_INSTR) begin
                next_sr = 64'(instr_value) << (7'd64 - ibits);
                next_rem = ibits;
            end else if (next_state == ST_ADDR) begin
                next_sr = 64'(next_addr) << (7'd64 - abits);
                next_rem = abits;
            end else if (next_state == ST_WAIT) begin
                next_wcnt = {enhanced_control[EC_WAIT_LSB +: 5], 1'b0};
            end else begin
                next_fb = 6'd0;
                next_rsr = 32'h0000_0000;
            end
        end
        next_w = ph_w(next_state);
        next_ss_n = (next_state == ST_IDLE);
        if (next_state == ST_INSTR || next_state == ST_ADDR) begin
            next_txd = LANE_N'(next_sr >> (7'd64 - 7'(next_w)));
            next_oe = LANE_N'((9'd1 << next_w) - 9'd1);
        end else begin
            next_txd = '0;
            next_oe = (!multi && next_state != ST_IDLE) ? LANE_N'(1) : '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            sr <= '0;
            rem <= 7'd0;
            wcnt <= 6'd0;
            fb <= 6'd0;
            frames <= 17'd0;
            rsr <= 32'h0000_0000;
            rx_word <= 32'h0000_0000;
            addr_lat <= 32'h0000_0000;
            par <= 1'b0;
            hold <= 1'b0;
            own_xip <= 1'b0;
            sclk_out <= 1'b0;
            ss_n <= 1'b1;
            txd <= '0;
            txd_oe <= '0;
            rxd_m <= '0;
            rxd_s <= '0;
        end else begin
            state <= next_state;
            sr <= next_sr;
            rem <= next_rem;
            wcnt <= next_wcnt;
            fb <= next_fb;
            frames <= next_frames;
            rsr <= next_rsr;
            rx_word <= next_rx_word;
            addr_lat <= next_addr;
            par <= next_par;
            hold <= next_hold;
            own_xip <= next_own;
            sclk_out <= next_sclk;
            ss_n <= next_ss_n;
            txd <= next_txd;
            txd_oe <= next_oe;
            rxd_m <= rxd;
            rxd_s <= rxd_m;
        end
    end
endmodule // ssx_enhanced_read
`default_nettype wire

// >>> testbench/ssx_enhanced_read_assertions.sv
/* checker on the bus and serial pins of the read block
   assumes: bound into ssx_enhanced_read, one clock domain */
`default_nettype none
module ssx_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic xip_en,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic ss_n,
    input wire logic [7:0] txd_oe,
    input wire logic sclk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_xip;
    assign rd_xip = hsel && htrans[1] && hready && xip_en && !hwrite;
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_stall; rd_xip |=> !hreadyout; endproperty
    a_stall: assert property (p_stall) else $error("read not stalled");
    property p_sel; rd_xip |-> ##[1:3] !ss_n; endproperty
    a_sel: assert property (p_sel) else $error("target not selected");
    property p_regs; hsel && htrans[1] && hready && !xip_en |=> hreadyout; endproperty
    a_regs: assert property (p_regs) else $error("register access waited");
    property p_bound; !hreadyout |-> ##[0:600] hreadyout; endproperty
    a_bound: assert property (p_bound) else $error("read never answered");
    property p_done; $rose(hreadyout) |-> $rose(ss_n); endproperty
    a_done: assert property (p_done) else $error("ready without deselect");
    property p_hold; !hreadyout && !$past(hreadyout) |-> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("data moved in stall");
    property p_start; $fell(ss_n) |-> $stable(sclk_out); endproperty
    a_start: assert property (p_start) else $error("clock moved at select");
    property p_quiet; ss_n |-> txd_oe == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("lane driven while deselected");
endmodule // ssx_checker
bind ssx_enhanced_read ssx_checker ssx_checker_inst (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .xip_en, .hreadyout, .hrdata, .hresp, .ss_n, .txd_oe, .sclk_out);
`default_nettype wire

// >>> testbench/ssx_flash_model.sv
/* serial memory model: fixed lane pattern while selected, address capture
   assumes: the memory samples on rising sclk_out */
`default_nettype none
module ssx_flash_model (
    input wire logic sclk_out,
    input wire logic ss_n,
    input wire logic [7:0] txd,
    input wire logic [3:0] lanes,
    input wire logic [6:0] abits,
    input wire logic [7:0] pat,
    output logic [7:0] rxd,
    output logic [31:0] got_addr,
    output var int edges
);
    timeunit 1ns;
    timeprecision 1ps;
    initial edges = 0;
    initial got_addr = 32'h0000_0000;
    always @(negedge ss_n) begin
        edges = 0;
        got_addr = 32'h0000_0000;
    end
    always @(posedge sclk_out) begin
        if (!ss_n && edges * lanes < abits)
            got_addr = (got_addr << lanes) | 32'(txd & ~(8'hff << lanes));
        if (!ss_n)
            edges = edges + 1;
    end
    // released lines show the inverse so a late sample cannot match
    assign rxd = ss_n ? ~pat : pat;
endmodule // ssx_flash_model
`default_nettype wire

// >>> testbench/testbench.sv
/* testbench: register and cache reads against the serial memory model
   assumes: one slave, so hready follows hreadyout */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ssx_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic xip_en = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, got_addr, q;
    logic hready, hreadyout, hresp, sclk_out, ss_n;
    logic [7:0] txd, txd_oe, rxd;
    logic [7:0] pat = 8'ha6;
    logic [3:0] lanes = 4'h1;
    logic [6:0] abits = 7'h00;
    logic [32:0] exp_q[$];
    logic pend = 1'b0;
    logic [7:0] ofs[7] = '{OFS_MAIN, OFS_ENH, OFS_FRAMES, OFS_DIV, OFS_EDGE, OFS_INSTR, 8'h30};
    logic [31:0] rv[7] = '{MAIN_RST, ENH_RST, 32'(FRAMES_RST), 32'(DIV_RST),
        32'(EDGE_RST), 32'(INSTR_RST), 32'h0000_0000};
    int edges;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int seed = 43876;
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    ssx_enhanced_read ssx_enhanced_read_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .xip_en,
        .sclk_out, .ss_n, .txd, .txd_oe, .rxd);
    ssx_flash_model ssx_flash_model_inst (.sclk_out, .ss_n, .txd, .lanes, .abits,
        .pat, .rxd, .got_addr, .edges);

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic c);
        exp_q.push_back({c, e});
        xfer(1'b0, a, 32'h0000_0000);
    endtask

    // expected word: each beat carries the pattern's low lanes, lane 1 in single-line, msb first
    function automatic logic [31:0] expw(input int l, input int fs);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < fs; i++)
            w[fs-1-i] = (l == 1) ? pat[1] : pat[l-1-(i%l)];
        return w;
    endfunction

    task automatic run(input int lf, fs, m3, ac, ic, w, dd, xip, nf, ne);
        logic [31:0] a;
        int l;
        l = 1 << lf;
        a = $random(seed);
        pat <= $random(seed);
        wr(OFS_MAIN, 32'((lf << MC_LANE_LSB) | (fs - 1) | (m3 * 32'h0000_00c0)));
        wr(OFS_ENH, 32'(PF_ALL_MULTI | (ac << EC_ALEN_LSB) | (ic << EC_ILEN_LSB)
            | (w << EC_WAIT_LSB) | (dd * 32'h0003_0000)));
        wr(OFS_DIV, dd ? 32'h0000_0008 : 32'h0000_0004);
        wr(OFS_EDGE, $random(seed) & (dd ? 32'h0000_0003 : 32'h0000_0001));
        wr(OFS_INSTR, 32'h0000_00eb);
        wr(OFS_FRAMES, 32'(nf));
        lanes <= 4'(l);
        abits <= dd ? 7'h00 : 7'(ac * 4);
        if (xip) begin
            xip_en <= 1'b1;
            rd(a, expw(l, fs), 1'b1);
            xip_en <= 1'b0;
            if (!dd)
                check("address", got_addr, 32'((33'h1 << (ac * 4)) - 33'h1) & a);
        end else begin
            wr(OFS_DATA, a);
            repeat (2) @(posedge hclk);
            q = 32'h0000_0001;
            while (q[0] === 1'b1)
                rd(OFS_STATUS, 32'h0000_0000, 1'b0);
            rd(OFS_DATA, expw(l, fs), 1'b1);
        end
        check("periods", edges, ne);
        $display("test done: lanes %0d xip %0d", l, xip);
    endtask

    always @(posedge hclk) begin
        if (pend && hready) begin
            if (exp_q[0][32])
                check("hrdata", hrdata, exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
        if (hready)
            pend <= hsel && htrans[1] && !hwrite;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ofs[i])
            rd({24'h00_0000, ofs[i]}, rv[i], 1'b1);
        $display("test done: reset values");
        for (int f = 1; f < 4; f++)
            run(f, 32, 0, 2 * f + 2, 0, 2, 0, 1, 0, (8 * f + 40) / (1 << f) + 2);
        run(2, 8, 0, 0, 0, 3, 0, 0, 1, 7);
        run(0, 8, 0, 0, 0, 1, 1, 0, 0, 9);
        run(2, 32, 1, 2, 2, 1, 1, 1, 0, 7);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
